// ===== hw/ofa_pkg.sv
// Package for the optic module alarm, flag and lane control block.
// Assumes a 32-bit APB slave with 12-bit byte addresses.
package ofa_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int VAL_W = 16;
  localparam int LANES = 4;
  localparam int N_ATTR = 10;
  localparam int N_LOS = 12;
  localparam int ATTR_FLAG_W = 40;

  // Word indices (byte address = 4 * index)
  localparam logic [5:0] W_VAL_LAST = 6'h09;
  localparam logic [2:0] W_THR_GRP = 3'h2;
  localparam logic [5:0] W_FLAG_LOS = 6'h18;
  localparam logic [5:0] W_FLAG_MOD = 6'h19;
  localparam logic [5:0] W_FLAG_TXB = 6'h1a;
  localparam logic [5:0] W_FLAG_RXP = 6'h1b;
  localparam logic [5:0] W_MASK_LOS = 6'h1c;
  localparam logic [5:0] W_MASK_MOD = 6'h1d;
  localparam logic [5:0] W_MASK_TXB = 6'h1e;
  localparam logic [5:0] W_MASK_RXP = 6'h1f;
  localparam logic [5:0] W_CTRL = 6'h20;
  localparam logic [5:0] W_STATUS = 6'h21;

  // Field positions
  localparam int CTRL_TX_OFF = 0;
  localparam int CTRL_RX_OFF = 4;
  localparam int CTRL_TX_SQ_DIS = 8;
  localparam int CTRL_RX_SQ_DIS = 9;
  localparam int CTRL_W = 10;
  localparam int LOS_TX = 0;
  localparam int LOS_RX = 4;
  localparam int LOS_FAULT = 8;
  localparam int STAT_PEND = 12;
  localparam int MOD_W = 8;
  localparam int LANE_FLAG_W = 16;

  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
  localparam logic [ATTR_FLAG_W-1:0] MASK_RST = 40'h00_0000_0000;
  localparam logic [N_LOS-1:0] LOS_MASK_RST = 12'h000;
  localparam logic [DATA_W-1:0] THR_RST = 32'hffff_0000;
  localparam logic [VAL_W-1:0] VAL_RST = 16'h0000;

  // Threshold set of one attribute kind
  typedef struct packed {
    logic [VAL_W-1:0] alarm_hi;
    logic [VAL_W-1:0] alarm_lo;
    logic [VAL_W-1:0] warn_hi;
    logic [VAL_W-1:0] warn_lo;
  } ofa_thr_t;

  // Lane event inputs, one bit per lane
  typedef struct packed {
    logic [LANES-1:0] tx_fault;
    logic [LANES-1:0] rx_los;
    logic [LANES-1:0] tx_los;
  } ofa_lane_t;

  // Threshold kind of attribute i: temp, supply, tx bias, rx power
  function automatic logic [1:0] ofa_kind(input int i);
    if (i < 2) begin
      return 2'(i);
    end
    return (i < 6) ? 2'h2 : 2'h3;
  endfunction : ofa_kind

endpackage : ofa_pkg

// ===== hw/ofa_thresh_cmp.sv
// Alarm and warning comparator for one monitored attribute.
// Assumes value and thresholds are unsigned codes on the same scale.
`timescale 1ns/1ps
`default_nettype none

module ofa_thresh_cmp (
  input wire logic [ofa_pkg::VAL_W-1:0] value,
  input wire ofa_pkg::ofa_thr_t thr,
  output logic [3:0] out_of_range
);
  import ofa_pkg::*;

  // Order: alarm high, alarm low, warning high, warning low
  assign out_of_range[3] = value > thr.alarm_hi;
  assign out_of_range[2] = value < thr.alarm_lo;
  assign out_of_range[1] = value > thr.warn_hi;
  assign out_of_range[0] = value < thr.warn_lo;

endmodule : ofa_thresh_cmp

`default_nettype wire

// ===== hw/ofa_alarm_ctrl.sv
// Monitor, latched flag, interrupt and lane control logic, APB slave.
// Assumes monitor codes come from same-clock logic; lane events are async.
//
// What this block does
// - Tx bias per lane, temperature and supply are readable values
// - Rx optical power per lane is a readable value
// - Out-of-threshold values set alarm/warning flags and interrupt
// - Tx input loss or Tx fault sets a flag and interrupt
// - Rx optical input loss sets a flag and interrupt
// - Flags stay set after their cause goes away
// - Reading a flag register clears the flags that were read
// - Each flag has a mask that keeps it off the interrupt
// - Tx input loss squelches Tx output unless squelch disabled
// - Tx fault or host deactivation disables the Tx lane
// - Rx loss squelches Rx output unless disabled; deactivation too
// - Interrupt output tells host of any new unmasked flag
// - Status, alarm, warning and fault registers are host readable
// - Block is only a bus slave; host is master
// - Each two-byte monitor value is read as one coherent word
// - Masks are volatile and return to default on reset
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module ofa_alarm_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ofa_pkg::ADDR_W-1:0] paddr,
  input wire logic [ofa_pkg::DATA_W-1:0] pwdata,
  output logic [ofa_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mon_update,
  input wire logic [ofa_pkg::VAL_W-1:0] mon_temp,
  input wire logic [ofa_pkg::VAL_W-1:0] mon_supply,
  input wire logic [ofa_pkg::LANES-1:0][ofa_pkg::VAL_W-1:0] mon_tx_bias,
  input wire logic [ofa_pkg::LANES-1:0][ofa_pkg::VAL_W-1:0] mon_rx_power,
  input wire ofa_pkg::ofa_lane_t lane_event_raw,
  output logic [ofa_pkg::LANES-1:0] tx_squelch,
  output logic [ofa_pkg::LANES-1:0] tx_disable,
  output logic [ofa_pkg::LANES-1:0] rx_squelch,
  output logic interrupt_request_n
);
  import ofa_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // State

  logic [N_LOS-1:0] ev_s1_q;
  logic [N_LOS-1:0] ev_s2_q;
  logic [VAL_W-1:0] val_q [N_ATTR];
  logic [DATA_W-1:0] thr_q [8];
  logic [ATTR_FLAG_W-1:0] attr_flag_q;
  logic [ATTR_FLAG_W-1:0] attr_mask_q;
  logic [N_LOS-1:0] los_flag_q;
  logic [N_LOS-1:0] los_mask_q;
  logic [CTRL_W-1:0] ctrl_q;
  logic [DATA_W-1:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_n_q;
  logic [LANES-1:0] tx_sq_q;
  logic [LANES-1:0] tx_dis_q;
  logic [LANES-1:0] rx_sq_q;
  logic [5:0] rd_word_q;

  //////////////////////////////////////////////////////////////////////////
  // Lane event synchroniser

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_s1_q <= 12'h000;
      ev_s2_q <= 12'h000;
    end else begin
      ev_s1_q <= lane_event_raw;
      ev_s2_q <= ev_s1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Monitor values and threshold comparison

  logic [VAL_W-1:0] mon_in [N_ATTR];
  logic [ATTR_FLAG_W-1:0] attr_set;

  assign mon_in[0] = mon_temp;
  assign mon_in[1] = mon_supply;

  for (genvar i = 0; i < N_ATTR; i++) begin : g_attr
    if (i >= 2 && i < 6) begin : g_bias
      assign mon_in[i] = mon_tx_bias[i-2];
    end else if (i >= 6) begin : g_rxp
      assign mon_in[i] = mon_rx_power[i-6];
    end
    localparam logic [1:0] K = ofa_kind(i);
    wire ofa_thr_t thr = {thr_q[{K, 1'b0}], thr_q[{K, 1'b1}]};

    ofa_thresh_cmp u_cmp (
      .value(val_q[i]),
      .thr(thr),
      .out_of_range(attr_set[4*i +: 4])
    );
  end

  // Whole 16-bit code latched in one edge keeps both bytes coherent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      val_q <= '{default: VAL_RST};
    end else if (mon_update) begin
      val_q <= mon_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // APB decode

  wire [5:0] word = paddr[7:2];
  wire in_page = (paddr[ADDR_W-1:8] == 4'h0) && (paddr[1:0] == 2'h0);
  wire val_hit = in_page && (word <= W_VAL_LAST);
  wire thr_hit = in_page && (word[5:3] == W_THR_GRP);
  wire reg_hit = in_page && (word >= W_FLAG_LOS) && (word <= W_STATUS);
  wire any_hit = val_hit || thr_hit || reg_hit;
  wire setup = psel && !penable;
  wire access = psel && penable && pready_q;
  wire wr = access && pwrite;
  wire rd_done = access && !pwrite;
  wire irq_pend = |(attr_flag_q & ~attr_mask_q) | |(los_flag_q & ~los_mask_q);

  logic [DATA_W-1:0] reg_rd;
  assign reg_rd =
      ({32{word == W_FLAG_LOS}} & 32'(los_flag_q)) |
      ({32{word == W_FLAG_MOD}} & 32'(attr_flag_q[MOD_W-1:0])) |
      ({32{word == W_FLAG_TXB}} & 32'(attr_flag_q[MOD_W +: LANE_FLAG_W])) |
      ({32{word == W_FLAG_RXP}} & 32'(attr_flag_q[ATTR_FLAG_W-1 -:
                                                   LANE_FLAG_W])) |
      ({32{word == W_MASK_LOS}} & 32'(los_mask_q)) |
      ({32{word == W_MASK_MOD}} & 32'(attr_mask_q[MOD_W-1:0])) |
      ({32{word == W_MASK_TXB}} & 32'(attr_mask_q[MOD_W +: LANE_FLAG_W])) |
      ({32{word == W_MASK_RXP}} & 32'(attr_mask_q[ATTR_FLAG_W-1 -:
                                                   LANE_FLAG_W])) |
      ({32{word == W_CTRL}} & 32'(ctrl_q)) |
      ({32{word == W_STATUS}} & 32'({irq_pend, ev_s2_q}));

  logic [DATA_W-1:0] rd_data;
  assign rd_data = val_hit ? 32'(val_q[word[3:0]]) :
                   thr_hit ? thr_q[word[2:0]] :
                   reg_hit ? reg_rd : 32'h0000_0000;

  // Read data is captured in setup, so access always completes in one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      rd_word_q <= 6'h00;
    end else begin
      pready_q <= setup;
      if (setup) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rd_data;
        pslverr_q <= !any_hit;
        rd_word_q <= word;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Configuration registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_q <= '{default: THR_RST};
    end else if (wr && thr_hit) begin
      thr_q[word[2:0]] <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      attr_mask_q <= MASK_RST;
      los_mask_q <= LOS_MASK_RST;
    end else if (wr && in_page) begin
      if (word == W_CTRL) begin
        ctrl_q <= pwdata[CTRL_W-1:0];
      end
      if (word == W_MASK_LOS) begin
        los_mask_q <= pwdata[N_LOS-1:0];
      end
      if (word == W_MASK_MOD) begin
        attr_mask_q[MOD_W-1:0] <= pwdata[MOD_W-1:0];
      end
      if (word == W_MASK_TXB) begin
        attr_mask_q[MOD_W +: LANE_FLAG_W] <= pwdata[LANE_FLAG_W-1:0];
      end
      if (word == W_MASK_RXP) begin
        attr_mask_q[ATTR_FLAG_W-1 -: LANE_FLAG_W] <= pwdata[LANE_FLAG_W-1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Latched flags; only bits returned by the read are cleared

  wire rd_ok = rd_done && !pslverr_q;
  wire [N_LOS-1:0] los_clr =
      (rd_ok && rd_word_q == W_FLAG_LOS) ? prdata_q[N_LOS-1:0] : 12'h000;
  wire [ATTR_FLAG_W-1:0] attr_clr = {
      (rd_ok && rd_word_q == W_FLAG_RXP) ? prdata_q[LANE_FLAG_W-1:0]
                                         : 16'h0000,
      (rd_ok && rd_word_q == W_FLAG_TXB) ? prdata_q[LANE_FLAG_W-1:0]
                                         : 16'h0000,
      (rd_ok && rd_word_q == W_FLAG_MOD) ? prdata_q[MOD_W-1:0] : 8'h00};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      los_flag_q <= 12'h000;
      attr_flag_q <= 40'h00_0000_0000;
    end else begin
      // Set wins over a clear in the same cycle
      los_flag_q <= (los_flag_q & ~los_clr) | ev_s2_q;
      attr_flag_q <= (attr_flag_q & ~attr_clr) | attr_set;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Lane control and interrupt outputs

  wire ofa_lane_t ev = ev_s2_q;
  wire tx_sq_dis = ctrl_q[CTRL_TX_SQ_DIS];
  wire rx_sq_dis = ctrl_q[CTRL_RX_SQ_DIS];
  wire [LANES-1:0] tx_off = ctrl_q[CTRL_TX_OFF +: LANES];
  wire [LANES-1:0] rx_off = ctrl_q[CTRL_RX_OFF +: LANES];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sq_q <= 4'h0;
      tx_dis_q <= 4'h0;
      rx_sq_q <= 4'h0;
      irq_n_q <= 1'b1;
    end else begin
      tx_sq_q <= ev.tx_los & {LANES{!tx_sq_dis}};
      tx_dis_q <= ev.tx_fault | tx_off;
      rx_sq_q <= (ev.rx_los & {LANES{!rx_sq_dis}}) | rx_off;
      irq_n_q <= !irq_pend;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign tx_squelch = tx_sq_q;
  assign tx_disable = tx_dis_q;
  assign rx_squelch = rx_sq_q;
  assign interrupt_request_n = irq_n_q;

  //////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_irq_on;
    irq_pend |=> !interrupt_request_n;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq not raised");

  property p_irq_off;
    !irq_pend |=> interrupt_request_n;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq held");

  property p_mask;
    (attr_set == 40'h00_0000_0000) && (ev_s2_q == 12'h000) &&
      ((attr_flag_q & ~attr_mask_q) == 40'h00_0000_0000) &&
      ((los_flag_q & ~los_mask_q) == 12'h000) && !wr |=>
      ##1 interrupt_request_n;
  endproperty
  a_mask: assert property (p_mask) else $error("masked flag raised irq");

  property p_sticky;
    los_clr == 12'h000 |=> (los_flag_q & $past(los_flag_q)) == $past(los_flag_q);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped");

  property p_lane_set;
    ev_s2_q != 12'h000 |=> (los_flag_q & $past(ev_s2_q)) == $past(ev_s2_q);
  endproperty
  a_lane_set: assert property (p_lane_set) else $error("lane flag missed");

  property p_rx_los;
    ev.rx_los != 4'h0 |=>
      (los_flag_q[LOS_RX +: LANES] & $past(ev.rx_los)) == $past(ev.rx_los);
  endproperty
  a_rx_los: assert property (p_rx_los) else $error("rx los flag missed");

  property p_thr_set;
    attr_set != 40'h00_0000_0000 |=>
      (attr_flag_q & $past(attr_set)) == $past(attr_set);
  endproperty
  a_thr_set: assert property (p_thr_set) else $error("threshold flag missed");

  property p_clr_read;
    rd_ok && rd_word_q == W_FLAG_LOS && ev_s2_q == 12'h000 |=>
      los_flag_q == ($past(los_flag_q) & ~$past(prdata_q[N_LOS-1:0]));
  endproperty
  a_clr_read: assert property (p_clr_read) else $error("read did not clear");

  property p_tx_sq;
    1'b1 |=> tx_squelch == ($past(ev.tx_los) & {LANES{!$past(tx_sq_dis)}});
  endproperty
  a_tx_sq: assert property (p_tx_sq) else $error("tx squelch wrong");

  property p_tx_dis;
    1'b1 |=> tx_disable == ($past(ev.tx_fault) | $past(tx_off));
  endproperty
  a_tx_dis: assert property (p_tx_dis) else $error("tx disable wrong");

  property p_rx_sq;
    rx_off != 4'h0 |=> (rx_squelch & $past(rx_off)) == $past(rx_off);
  endproperty
  a_rx_sq: assert property (p_rx_sq) else $error("rx squelch wrong");

  property p_ready;
    setup |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready) else $error("apb ready timing");

  property p_val_read;
    setup && !pwrite && val_hit |=> prdata == 32'($past(val_q[word[3:0]]));
  endproperty
  a_val_read: assert property (p_val_read) else $error("monitor read wrong");

  c_irq: cover property (irq_pend ##1 !interrupt_request_n);
  c_clr: cover property (los_clr != 12'h000);
  c_ctrl_wr: cover property (wr && word == W_CTRL);
  c_err: cover property (access && pslverr);

endmodule : ofa_alarm_ctrl

`default_nettype wire

// ===== dv/ofa_host_model.sv
// Host model: APB master reaching the alarm block's registers.
// Assumes one clock; the bench calls xfer for every transfer.
`timescale 1ns/1ps
`default_nettype none

module ofa_host_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [ofa_pkg::ADDR_W-1:0] paddr,
  output logic [ofa_pkg::DATA_W-1:0] pwdata,
  input wire logic [ofa_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  import ofa_pkg::*;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One transfer as bus master; t flags a missing answer
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q,
                      output logic e, output logic t);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge pclk);
      n++;
    end
    t = (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines show a changed pattern, not the old value
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer

endmodule : ofa_host_model

`default_nettype wire

// ===== dv/ofa_alarm_ctrl_tb_top.sv
// Testbench for the alarm, flag and lane control block.
// Assumes the host model as bus master; bench drives monitors and events.
`timescale 1ns/1ps
`default_nettype none

module ofa_alarm_ctrl_tb_top;
  import ofa_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mon_update;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic [VAL_W-1:0] mon_temp, mon_supply;
  logic [LANES-1:0][VAL_W-1:0] mon_tx_bias, mon_rx_power;
  ofa_lane_t lane_ev;
  logic [LANES-1:0] tx_sq, tx_dis, rx_sq;
  logic irq_n;
  int fail_count = 0;
  int checks_done = 0;

  initial pclk = 1'b0;
  always #2.5 pclk = ~pclk;

  ofa_alarm_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mon_update(mon_update), .mon_temp(mon_temp), .mon_supply(mon_supply),
    .mon_tx_bias(mon_tx_bias), .mon_rx_power(mon_rx_power),
    .lane_event_raw(lane_ev), .tx_squelch(tx_sq), .tx_disable(tx_dis),
    .rx_squelch(rx_sq), .interrupt_request_n(irq_n));

  ofa_host_model host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s: got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    logic t;
    host.xfer(w, a, d, q, e, t);
    if (t) begin
      fail_count++;
      $display("[ERR] %0t no bus answer", $time);
      stop_test();
    end
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    bus(1'b1, a, d, q, e);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp,
                     input logic ee, input string m);
    logic [31:0] q;
    logic e;
    bus(1'b0, a, 32'h0000_0000, q, e);
    chk(q, exp, m);
    chk({31'h0, e}, {31'h0, ee}, m);
  endtask : rdc

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  task automatic mon(input logic [15:0] t, input logic [15:0] s);
    @(posedge pclk);
    mon_temp <= t;
    mon_supply <= s;
    mon_update <= 1'b1;
    @(posedge pclk);
    mon_update <= 1'b0;
    cyc(3);
  endtask : mon

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk({19'h0, irq_n, rx_sq, tx_dis, tx_sq}, 32'h1000, "idle");
    for (int i = 0; i < 4; i++) begin
      rdc(12'h070 + 12'(4 * i), 32'h0000_0000, 1'b0, "mask");
    end
    rdc(12'h080, 32'h0000_0000, 1'b0, "ctrl");
    rdc(12'h040, 32'hffff_0000, 1'b0, "thr");
    rdc(12'h0fc, 32'h0000_0000, 1'b1, "unmapped");
    $display("t_reset done");
  endtask : t_reset

  task automatic t_values();
    @(posedge pclk);
    for (int i = 0; i < LANES; i++) begin
      mon_tx_bias[i] <= 16'h0100 + 16'(i);
      mon_rx_power[i] <= 16'h0200 + 16'(i);
    end
    mon(16'h0050, 16'h0222);
    wr(12'h000, 32'hdead_beef);
    rdc(12'h000, 32'h0000_0050, 1'b0, "temp");
    rdc(12'h004, 32'h0000_0222, 1'b0, "supply");
    for (int i = 0; i < LANES; i++) begin
      rdc(12'h008 + 12'(4 * i), 32'h0000_0100 + 32'(i), 1'b0,
          "bias");
      rdc(12'h018 + 12'(4 * i), 32'h0000_0200 + 32'(i), 1'b0,
          "rxpwr");
    end
    $display("t_values done");
  endtask : t_values

  task automatic t_thresh();
    wr(12'h040, 32'h0100_0010);
    wr(12'h044, 32'h00c0_0020);
    wr(12'h048, 32'hffff_0100);
    wr(12'h074, 32'h0000_00ff);
    rdc(12'h064, 32'h0000_0000, 1'b0, "no flag");
    mon(16'h0200, 16'h0050);
    chk({31'h0, irq_n}, 32'h1, "masked");
    mon(16'h0050, 16'h0222);
    rdc(12'h064, 32'h0000_004a, 1'b0, "masked flag");
    wr(12'h074, 32'h0000_0000);
    mon(16'h0200, 16'h0050);
    chk({31'h0, irq_n}, 32'h0, "irq");
    mon(16'h0050, 16'h0222);
    cyc(4);
    chk({31'h0, irq_n}, 32'h0, "irq held");
    rdc(12'h064, 32'h0000_004a, 1'b0, "sticky");
    rdc(12'h064, 32'h0000_0000, 1'b0, "cleared");
    cyc(2);
    chk({31'h0, irq_n}, 32'h1, "irq off");
    $display("t_thresh done");
  endtask : t_thresh

  task automatic t_lanes();
    @(posedge pclk);
    lane_ev <= 12'h421;
    cyc(5);
    chk({20'h0, rx_sq, tx_dis, tx_sq}, 32'h241, "lanes");
    chk({31'h0, irq_n}, 32'h0, "lane irq");
    rdc(12'h084, 32'h0000_1421, 1'b0, "status");
    @(posedge pclk);
    lane_ev <= 12'h000;
    cyc(5);
    rdc(12'h060, 32'h0000_0421, 1'b0, "los flags");
    rdc(12'h060, 32'h0000_0000, 1'b0, "los clr");
    wr(12'h080, 32'h0000_0342);
    @(posedge pclk);
    lane_ev <= 12'h088;
    cyc(5);
    chk({20'h0, rx_sq, tx_dis, tx_sq}, 32'h420, "ctrl");
    @(posedge pclk);
    lane_ev <= 12'h000;
    wr(12'h080, 32'h0000_0000);
    cyc(5);
    chk({20'h0, rx_sq, tx_dis, tx_sq}, 32'h000, "lane on");
    rdc(12'h060, 32'h0000_0088, 1'b0, "los2");
    cyc(2);
    chk({31'h0, irq_n}, 32'h1, "irq off");
    $display("t_lanes done");
  endtask : t_lanes

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    mon_update = 1'b0;
    mon_temp = '0;
    mon_supply = '0;
    mon_tx_bias = '0;
    mon_rx_power = '0;
    lane_ev = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_values();
    t_thresh();
    t_lanes();
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    $display("[ERR] %0t run timed out", $time);
    stop_test();
  end

endmodule : ofa_alarm_ctrl_tb_top

`default_nettype wire
